// *** include/buck2_cfg.svh ***
`ifndef BUCK2_CFG_SVH
`define BUCK2_CFG_SVH

// Register byte offsets
`define BUCK2_OFS_LEVEL 8'h20
`define BUCK2_OFS_MODE 8'h21
`define BUCK2_OFS_RSVD 8'h22
`define BUCK2_OFS_ENABLE 8'h23

// Field positions
`define BUCK2_BAND_BIT 6
`define BUCK2_CODE_MSB 5
`define BUCK2_MODE_BIT 0
`define BUCK2_EN_BIT 0
`define BUCK2_PGOOD_BIT 1
`define BUCK2_WEXACT_BIT 2

// Reset values of the writable fields
`define BUCK2_RST_CODE 6'h00
`define BUCK2_RST_BAND 1'h0
`define BUCK2_RST_MODE 1'h0
`define BUCK2_RST_EN 1'h0
`define BUCK2_RST_WEXACT 1'h0

// Output level arithmetic, millivolts
`define BUCK2_LOW_FIRST_CODE 6'h12
`define BUCK2_HIGH_BASE_MV 13'h04e2
`define BUCK2_HIGH_STEP_MV 13'h0032

`endif

// *** include/buck2_pkg.sv ***
`default_nettype none
package buck2_pkg;
    // One register byte
    typedef logic [7:0] reg_byte_t;
    // Output level code
    typedef logic [5:0] level_code_t;
    // Target level in millivolts
    typedef logic [12:0] millivolt_t;
    // Switching behaviour
    typedef enum logic {mode_auto_skip, mode_fixed_freq} switch_mode_t;
endpackage : buck2_pkg
`default_nettype wire

// *** rtl/output_level_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "buck2_cfg.svh"

module output_level_decode (
    input wire logic [5:0] level_code_in,
    input wire logic level_band_select_in,
    output logic [12:0] target_mv_out,
    output logic code_valid_out
);
    // Low band steps are uneven, so it is a table, not arithmetic
    buck2_pkg::millivolt_t low_mv;
    // High band is a plain linear ramp
    buck2_pkg::millivolt_t high_mv;
    logic low_valid;

    assign high_mv = `BUCK2_HIGH_BASE_MV
        + 13'({7'h00, level_code_in} * `BUCK2_HIGH_STEP_MV);
    assign low_valid = (level_code_in >= `BUCK2_LOW_FIRST_CODE);

    // Low band lookup; unavailable codes give zero
    always_comb begin
        low_mv = 13'h0000;
        case (level_code_in)
            6'h12: low_mv = 13'h044c;
            6'h13: low_mv = 13'h0465;
            6'h14: low_mv = 13'h047e;
            6'h15: low_mv = 13'h0497;
            6'h16: low_mv = 13'h04b0;
            6'h17: low_mv = 13'h04c9;
            6'h18: low_mv = 13'h04e7;
            6'h19: low_mv = 13'h0500;
            6'h1a: low_mv = 13'h0519;
            6'h1b: low_mv = 13'h0532;
            6'h1c: low_mv = 13'h054b;
            6'h1d: low_mv = 13'h0564;
            6'h1e: low_mv = 13'h057d;
            6'h1f: low_mv = 13'h0596;
            6'h20: low_mv = 13'h05af;
            6'h21: low_mv = 13'h05c8;
            6'h22: low_mv = 13'h05e1;
            6'h23: low_mv = 13'h05fa;
            6'h24: low_mv = 13'h0613;
            6'h25: low_mv = 13'h0631;
            6'h26: low_mv = 13'h064a;
            6'h27: low_mv = 13'h0663;
            6'h28: low_mv = 13'h067c;
            6'h29: low_mv = 13'h0695;
            6'h2a: low_mv = 13'h06ae;
            6'h2b: low_mv = 13'h06c7;
            6'h2c: low_mv = 13'h06e0;
            6'h2d: low_mv = 13'h06f9;
            6'h2e: low_mv = 13'h0712;
            6'h2f: low_mv = 13'h072b;
            6'h30: low_mv = 13'h0744;
            6'h31: low_mv = 13'h0762;
            6'h32: low_mv = 13'h077b;
            6'h33: low_mv = 13'h0794;
            6'h34: low_mv = 13'h07ad;
            6'h35: low_mv = 13'h07c6;
            6'h36: low_mv = 13'h07df;
            6'h37: low_mv = 13'h07f8;
            6'h38: low_mv = 13'h0811;
            6'h39: low_mv = 13'h082a;
            6'h3a: low_mv = 13'h0843;
            6'h3b: low_mv = 13'h085c;
            6'h3c: low_mv = 13'h0875;
            6'h3d: low_mv = 13'h088e;
            6'h3e: low_mv = 13'h0898;
            6'h3f: low_mv = 13'h08c5;
            default: low_mv = 13'h0000;
        endcase
    end

    // Band select picks the high band ramp or the low band table
    assign target_mv_out = level_band_select_in ? high_mv : low_mv;
    assign code_valid_out = level_band_select_in | low_valid;
endmodule : output_level_decode
`default_nettype wire

// *** rtl/second_buck_channel_regs.sv ***
// Operation
// - Offset 0x20 bits 5:0 hold level code
// - Low band codes below 0x12 unavailable
// - High band: 1.25 V plus 50 mV steps
// - Offset 0x21 bit zero forces fixed frequency
// - Read-only bits ignore writes; all but power good read zero
// - Offset 0x23 bit one shows power good
`timescale 1ns/1ps
`default_nettype none
`include "buck2_cfg.svh"

module second_buck_channel_regs (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic power_good_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_ack_out,
    output logic [5:0] level_code_out,
    output logic level_band_select_out,
    output logic switch_mode_out,
    output logic channel_enable_out,
    output logic [12:0] target_mv_out,
    output logic code_valid_out
);
    // Writable fields
    buck2_pkg::level_code_t level_code_q;
    logic level_band_q;
    buck2_pkg::switch_mode_t switch_mode_q;
    logic enable_q;
    // Write-exact bit, stored and read back only
    logic wexact_q;
    // Power-good synchroniser; comparator is asynchronous to us
    logic pgood_meta_q;
    logic pgood_q;
    // Read port
    buck2_pkg::reg_byte_t rdata_q;
    logic ack_q;
    // Decoded target, registered so outputs come from flops
    buck2_pkg::millivolt_t target_mv_q;
    logic code_valid_q;

    // Address decode
    logic hit_level;
    logic hit_mode;
    logic hit_rsvd;
    logic hit_enable;
    logic wr_level;
    logic wr_mode;
    logic wr_enable;
    buck2_pkg::reg_byte_t read_value;
    buck2_pkg::millivolt_t dec_mv;
    logic dec_valid;

    assign hit_level = (reg_addr_in == `BUCK2_OFS_LEVEL);
    assign hit_mode = (reg_addr_in == `BUCK2_OFS_MODE);
    assign hit_rsvd = (reg_addr_in == `BUCK2_OFS_RSVD);
    assign hit_enable = (reg_addr_in == `BUCK2_OFS_ENABLE);
    // Writes to 0x22 or unmapped offsets have no target at all
    assign wr_level = reg_wr_in & hit_level;
    assign wr_mode = reg_wr_in & hit_mode;
    assign wr_enable = reg_wr_in & hit_enable;

    // Read mux; read-only bits other than power good, and unmapped bits, read as zero
    assign read_value =
        hit_level ? {1'b0, level_band_q, level_code_q} :
        hit_mode ? {7'h00, switch_mode_q} :
        hit_enable ? {5'h00, wexact_q, pgood_q, enable_q} :
        8'h00;

    // Level code and band, from offset 0x20
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_code_q <= `BUCK2_RST_CODE;
            level_band_q <= `BUCK2_RST_BAND;
        end else if (wr_level) begin
            // Bit 7 dropped on purpose
            level_code_q <= reg_wdata_in[`BUCK2_CODE_MSB:0];
            level_band_q <= reg_wdata_in[`BUCK2_BAND_BIT];
        end
    end

    // Switching mode, from offset 0x21
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switch_mode_q <= buck2_pkg::switch_mode_t'(`BUCK2_RST_MODE);
        end else if (wr_mode) begin
            switch_mode_q <= buck2_pkg::switch_mode_t'(
                reg_wdata_in[`BUCK2_MODE_BIT]);
        end
    end

    // Enable and write-exact bit, from offset 0x23
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_q <= `BUCK2_RST_EN;
            wexact_q <= `BUCK2_RST_WEXACT;
        end else if (wr_enable) begin
            enable_q <= reg_wdata_in[`BUCK2_EN_BIT];
            // Stored as given; the host must write the default
            wexact_q <= reg_wdata_in[`BUCK2_WEXACT_BIT];
        end
    end

    // Two-flop synchroniser for the power-good comparator
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pgood_meta_q <= 1'b0;
            pgood_q <= 1'b0;
        end else begin
            pgood_meta_q <= power_good_in;
            pgood_q <= pgood_meta_q;
        end
    end

    // Read data and acknowledge, one cycle after the strobe
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            ack_q <= reg_wr_in | reg_rd_in;
            if (reg_rd_in) begin
                rdata_q <= read_value;
            end
        end
    end

    // Level decoder
    output_level_decode u_decode (
        .level_code_in(level_code_q),
        .level_band_select_in(level_band_q),
        .target_mv_out(dec_mv),
        .code_valid_out(dec_valid)
    );

    // Registered decode; lags the field by one cycle
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            target_mv_q <= 13'h0000;
            code_valid_q <= 1'b0;
        end else begin
            target_mv_q <= dec_mv;
            code_valid_q <= dec_valid;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_ack_out = ack_q;
    assign level_code_out = level_code_q;
    assign level_band_select_out = level_band_q;
    assign switch_mode_out = switch_mode_q;
    assign channel_enable_out = enable_q;
    assign target_mv_out = target_mv_q;
    assign code_valid_out = code_valid_q;

    // Checks on the register behaviour
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_code_write: assert property (
        wr_level |=> level_code_q == $past(reg_wdata_in[5:0]))
        else $error("level code not stored");
    chk_band_write: assert property (
        wr_level |=> level_band_q == $past(reg_wdata_in[6]))
        else $error("band select not stored");
    chk_low_band: assert property (
        (!level_band_q && level_code_q < 6'h12) ##1
        ($stable(level_code_q) && !level_band_q) |-> !code_valid_out)
        else $error("unavailable low code flagged valid");
    chk_low_first: assert property (
        (!level_band_q && level_code_q == 6'h12) |=>
        target_mv_out == 13'h044c)
        else $error("low band first code wrong");
    chk_high_step: assert property (
        level_band_q |=> code_valid_out && target_mv_out ==
        13'h04e2 + 13'({7'h00, $past(level_code_q)} * 13'h0032))
        else $error("high band level wrong");
    chk_mode_write: assert property (
        wr_mode |=> switch_mode_q == $past(reg_wdata_in[0]))
        else $error("mode not stored");
    chk_ro_zero: assert property (
        reg_rd_in && (hit_rsvd || hit_level) |=>
        reg_rdata_out[7] == 1'b0 && (!$past(hit_rsvd) ||
        reg_rdata_out == 8'h00))
        else $error("read-only bits not zero");
    chk_pgood_read: assert property (
        reg_rd_in && hit_enable |=> reg_rdata_out[1] == $past(pgood_q))
        else $error("power good readback wrong");
    chk_enable_write: assert property (
        wr_enable |=> channel_enable_out == $past(reg_wdata_in[0]))
        else $error("enable not stored");
    chk_stray_write: assert property (
        reg_wr_in && !hit_level && !hit_mode && !hit_enable |=>
        $stable(level_code_q) && $stable(level_band_q) &&
        $stable(switch_mode_q) && $stable(enable_q) && $stable(wexact_q))
        else $error("stray write changed a field");

    cov_enable_on: cover property (wr_enable && reg_wdata_in[0]);
    cov_high_band: cover property (wr_level && reg_wdata_in[6]);
    cov_low_bad: cover property (wr_level && reg_wdata_in[6:0] < 7'h12);
    cov_pgood_read: cover property (reg_rd_in && hit_enable && pgood_q);
endmodule : second_buck_channel_regs
`default_nettype wire

// *** tb/host_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_master_model (
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    // Bus idle from time zero
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // One byte transfer; a missing ack hands back unknown data
    task automatic xfer(input logic is_wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= is_wr;
        rd_out <= !is_wr;
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        // Released lines flip so stale values cannot pass
        addr_out <= ~a;
        wdata_out <= ~d;
        for (n = 0; n < 8; n++) begin
            @(posedge clk_in);
            if (ack_in === 1'b1) break;
        end
        q = (ack_in === 1'b1) ? rdata_in : 8'hxx;
    endtask : xfer
endmodule : host_master_model

`default_nettype wire

// *** tb/buck_channel_two_control_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module buck_channel_two_control_regs_tb;
    logic clk;
    logic rst_n;
    logic pg;
    logic [7:0] addr, wdata, rdata, junk;
    logic wr, rd, ack, band, mode, en, valid;
    logic [5:0] code;
    logic [12:0] mv;
    int num_errors = 0;
    int comparisons = 0;

    second_buck_channel_regs i_dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .power_good_in(pg), .reg_rdata_out(rdata), .reg_ack_out(ack),
        .level_code_out(code), .level_band_select_out(band),
        .switch_mode_out(mode), .channel_enable_out(en),
        .target_mv_out(mv), .code_valid_out(valid)
    );

    host_master_model i_host (
        .clk_in(clk), .ack_in(ack), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd)
    );

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Single comparison point
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        i_host.xfer(1'b1, a, d, junk);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        i_host.xfer(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask : rd_chk

    // Everything reads zero out of reset, unmapped place too
    task automatic test_reset;
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'h20 + 8'(i), 8'h00);
        end
    endtask : test_reset

    // Band and code pairs; target lags the field by one edge
    task automatic test_level;
        logic [7:0] set_v[6] = '{8'hff, 8'h40, 8'h11, 8'h12, 8'h3f, 8'h00};
        logic [13:0] exp_v[6] = '{14'h3130, 14'h24e2, 14'h0000, 14'h244c,
                                  14'h28c5, 14'h0000};
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h20, set_v[i]);
            rd_chk(8'h20, set_v[i] & 8'h7f);
            chk({9'h000, band, code}, {8'h00, set_v[i] & 8'h7f});
            chk({2'h0, valid, mv}, {2'h0, exp_v[i]});
        end
    endtask : test_level

    // Mode, reserved byte, enable and power good
    task automatic test_misc;
        wr_reg(8'h21, 8'hff);
        rd_chk(8'h21, 8'h01);
        chk({15'h0000, mode}, 16'h0001);
        wr_reg(8'h21, 8'hfe);
        rd_chk(8'h21, 8'h00);
        chk({15'h0000, mode}, 16'h0000);
        wr_reg(8'h22, 8'hff);
        rd_chk(8'h22, 8'h00);
        wr_reg(8'h23, 8'hfb);
        rd_chk(8'h23, 8'h01);
        chk({15'h0000, en}, 16'h0001);
        pg <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'h23, 8'h03);
        wr_reg(8'h23, 8'h00);
        rd_chk(8'h23, 8'h02);
        chk({15'h0000, en}, 16'h0000);
        // Comparator drops again; flag must follow
        pg <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(8'h23, 8'h00);
    endtask : test_misc

    // Reset in mid-run returns every field to zero
    task automatic test_mid_reset;
        wr_reg(8'h20, 8'h7f);
        wr_reg(8'h21, 8'h01);
        wr_reg(8'h23, 8'h01);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk({7'h00, band, code, mode, en}, 16'h0000);
        chk({2'h0, valid, mv}, 16'h0000);
        test_reset();
    endtask : test_mid_reset

    task automatic print_verdict;
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        num_errors = num_errors + 1;
        print_verdict();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        pg = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_level();
        test_misc();
        test_mid_reset();
        print_verdict();
    end
endmodule : buck_channel_two_control_regs_tb

`default_nettype wire
